// File: verilog/iess_pkg.sv
// Constants and types for the enable-status and spike-filter block
//
// Notes on behaviour
// - Disable during slave receive after one full data byte: set lost
// - Stop before NACK does not clear busy or lost
// - Disable during slave address or receive: busy
// - Busy flag means the slave was engaged when disabled
// - Busy flag zero if idle or master traffic
// - Status bit zero mirrors the enable output
// - Flags stable whenever enable status reads zero
// - Filter line glitches up to spike length
// - Spike length written only while disabled
// - Spike length writes below two store two
package iess_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_ENABLE_STATUS = 32'h5000139c;
  localparam logic [31:0] ADDR_SPIKE_LEN = 32'h500013a0;
  localparam logic [31:0] ADDR_CONTROL = 32'h500013a4;
  localparam logic [31:0] ADDR_OWN_ADDR = 32'h500013a8;
  localparam logic [31:0] ADDR_INT_STATUS = 32'h500013ac;
  localparam logic [31:0] ADDR_INT_MASK = 32'h500013b0;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EN_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int LOST_BIT = 2;
  localparam int INT_BUSY_BIT = 0;
  localparam int INT_LOST_BIT = 1;
  localparam logic [7:0] SPIKE_RESET = 8'h01;
  localparam logic [7:0] SPIKE_MIN = 8'h02;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h55;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Slave activity tracker
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    TRK_IDLE = 7'h01,
    TRK_ADDR = 7'h02,
    TRK_ADDR_ACK = 7'h04,
    TRK_RX = 7'h08,
    TRK_RX_ACK = 7'h10,
    TRK_TX = 7'h20,
    TRK_IGNORE = 7'h40
  } iess_trk_e;

endpackage

// File: verilog/iess_line_if.sv
// Filtered bus lines passed from the spike filter to the tracker
`timescale 1ns/1ns
`default_nettype none
interface iess_line_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface
`default_nettype wire

// File: verilog/iess_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module iess_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Lines
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } iess_sync_s;

  iess_sync_s r;
  iess_sync_s next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= {RESET_VAL, RESET_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// File: verilog/iess_spike_filter.sv
// Spike suppression on the synchronised clock and data lines
`timescale 1ns/1ns
`default_nettype none
module iess_spike_filter #(
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw lines, already synchronised: bit 1 clock, bit 0 data
  input wire logic [1:0] raw,
  input wire logic [LEN_W-1:0] spike_len,
  // Filtered lines
  iess_line_if.src lines
);
  typedef struct packed {
    logic [1:0] out;
    logic [1:0][LEN_W:0] cnt;
  } iess_filt_s;

  iess_filt_s r;
  iess_filt_s next_r;

  // A level must differ for more than spike_len cycles to pass
  always_comb begin
    next_r = r;
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == r.out[i]) begin
        next_r.cnt[i] = '0;
      end else if (r.cnt[i] >= {1'b0, spike_len}) begin
        next_r.out[i] = raw[i];
        next_r.cnt[i] = '0;
      end else begin
        next_r.cnt[i] = r.cnt[i] + (LEN_W+1)'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{out: 2'h3, cnt: '0};
    end else begin
      r <= next_r;
    end
  end

  assign lines.scl = r.out[1];
  assign lines.sda = r.out[0];
endmodule
`default_nettype wire

// File: verilog/iess_top.sv
// Enable status, disable-while-busy flags and spike filter of a
// two-wire bus controller, with an AXI4-Lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module iess_top
  import iess_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Controller side
  output logic enable_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] awaddr;
    logic aw_held;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_en;
    logic en_status;
    logic [7:0] spike_len;
    logic [6:0] own_addr;
    logic busy_flag;
    logic lost_flag;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic irq;
    iess_trk_e trk;
    logic [3:0] bits;
    logic [7:0] shift;
    logic matched;
    logic rx_got;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
  } iess_top_s;

  iess_top_s r;
  iess_top_s next_r;

  logic [1:0] raw_sync;
  iess_line_if lines ();

  // ----------------------------------------------------------------
  // Line input path
  // ----------------------------------------------------------------
  iess_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({scl_i, sda_i}),
    .q(raw_sync)
  );

  iess_spike_filter #(.LEN_W(8)) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(raw_sync),
    .spike_len(r.spike_len),
    .lines(lines)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Tracker states in which the slave side is engaged
  function automatic logic slave_engaged(input iess_trk_e s);
    return s inside {TRK_ADDR, TRK_ADDR_ACK, TRK_RX, TRK_RX_ACK};
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return a inside {ADDR_ENABLE_STATUS, ADDR_SPIKE_LEN, ADDR_CONTROL,
                     ADDR_OWN_ADDR, ADDR_INT_STATUS, ADDR_INT_MASK};
  endfunction

  // Upper bits stay zero in every word
  function automatic logic [31:0] read_word(input logic [31:0] a,
                                            input iess_top_s s);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ADDR_ENABLE_STATUS: begin
        v[EN_BIT] = s.en_status;
        v[BUSY_BIT] = s.busy_flag;
        v[LOST_BIT] = s.lost_flag;
      end
      ADDR_SPIKE_LEN: v[7:0] = s.spike_len;
      ADDR_CONTROL: v[0] = s.ctrl_en;
      ADDR_OWN_ADDR: v[6:0] = s.own_addr;
      ADDR_INT_STATUS: v[1:0] = s.int_status;
      ADDR_INT_MASK: v[1:0] = s.int_mask;
      default: v = '0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic do_write;
  logic disable_edge;
  logic ev_busy;
  logic ev_lost;

  always_comb begin
    next_r = r;
    scl_rise = lines.scl && !r.scl_d;
    scl_fall = !lines.scl && r.scl_d;
    start_cond = lines.scl && r.scl_d && r.sda_d && !lines.sda;
    stop_cond = lines.scl && r.scl_d && !r.sda_d && lines.sda;
    do_write = r.aw_held && r.w_held && !r.bvalid;
    disable_edge = 1'b0;
    ev_busy = 1'b0;
    ev_lost = 1'b0;
    next_r.scl_d = lines.scl;
    next_r.sda_d = lines.sda;

    // Write address and data are taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.awaddr = s_axi_awaddr;
      next_r.aw_held = 1'b1;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.w_held = 1'b1;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (do_write) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (r.wstrb[0]) begin
        unique case (r.awaddr)
          ADDR_CONTROL: begin
            next_r.ctrl_en = r.wdata[0];
            disable_edge = r.ctrl_en && !r.wdata[0];
          end
          ADDR_SPIKE_LEN: begin
            if (!r.ctrl_en) begin
              next_r.spike_len = (r.wdata[7:0] < SPIKE_MIN) ?
                                 SPIKE_MIN : r.wdata[7:0];
            end
          end
          ADDR_OWN_ADDR: next_r.own_addr = r.wdata[6:0];
          ADDR_INT_STATUS: next_r.int_status = r.int_status & ~r.wdata[1:0];
          ADDR_INT_MASK: next_r.int_mask = r.wdata[1:0];
          default: next_r.ctrl_en = r.ctrl_en;
        endcase
      end
    end
    next_r.awready = !next_r.aw_held;
    next_r.wready = !next_r.w_held;

    // Read channel: one read at a time
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = read_word(s_axi_araddr, r);
      next_r.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_r.arready = !next_r.rvalid;

    // Flags are captured at the instant the enable is cleared, so a
    // later stop from the remote master cannot wipe them
    if (disable_edge) begin
      ev_busy = slave_engaged(r.trk);
      ev_lost = (r.trk inside {TRK_RX, TRK_RX_ACK}) && r.rx_got;
      next_r.busy_flag = ev_busy;
      next_r.lost_flag = ev_lost;
    end
    if (!r.ctrl_en && next_r.ctrl_en) begin
      next_r.en_status = 1'b1;
    end else if (!r.ctrl_en && !slave_engaged(r.trk)) begin
      // Enable output stays up until a forced NACK or a stop ends engagement
      next_r.en_status = 1'b0;
    end

    // Slave activity tracker
    if (start_cond) begin
      next_r.trk = TRK_ADDR;
      next_r.bits = '0;
      next_r.rx_got = 1'b0;
      next_r.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_r.trk = TRK_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      unique case (r.trk)
        TRK_IDLE, TRK_TX, TRK_IGNORE: next_r.trk = r.trk;
        TRK_ADDR, TRK_RX: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], lines.sda};
            next_r.bits = r.bits + 4'h1;
            if (r.trk == TRK_RX && r.bits == BITS_PER_BYTE - 4'h1) begin
              next_r.rx_got = 1'b1;
            end
          end else if (scl_fall && r.bits == BITS_PER_BYTE) begin
            next_r.bits = '0;
            if (r.trk == TRK_ADDR) begin
              next_r.trk = TRK_ADDR_ACK;
              next_r.matched = r.shift[7:1] == r.own_addr;
              next_r.sda_oe = r.ctrl_en && r.shift[7:1] == r.own_addr;
            end else begin
              next_r.trk = TRK_RX_ACK;
              next_r.sda_oe = r.ctrl_en;
            end
          end
        end
        TRK_ADDR_ACK: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            if (!r.matched || !r.sda_oe) begin
              next_r.trk = TRK_IGNORE;
            end else begin
              next_r.trk = r.shift[0] ? TRK_TX : TRK_RX;
            end
          end
        end
        TRK_RX_ACK: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.trk = r.sda_oe ? TRK_RX : TRK_IGNORE;
          end
        end
      endcase
    end

    // Interrupt: set wins over a clear in the same cycle
    if (ev_busy) begin
      next_r.int_status[INT_BUSY_BIT] = 1'b1;
    end
    if (ev_lost) begin
      next_r.int_status[INT_LOST_BIT] = 1'b1;
    end
    next_r.irq = |(next_r.int_status & next_r.int_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.spike_len <= SPIKE_RESET;
      r.own_addr <= OWN_ADDR_RESET;
      r.trk <= TRK_IDLE;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  // Open drain: the pin value is always low, only the enable moves
  assign sda_o = r.shift[0] & 1'b0;
  assign sda_oe = r.sda_oe;
  assign enable_out = r.en_status;
  assign irq = r.irq;

endmodule
`default_nettype wire

// File: dv/iess_sva.sv
// Port assertions for the enable-status and spike-filter block
`timescale 1ns/1ns
`default_nettype none
module iess_sva
  import iess_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus pin and status
  input wire logic sda_oe,
  input wire logic enable_out
);
  // ------------------------------------------------------------
  // Address of the read in flight
  // ------------------------------------------------------------
  logic [31:0] rd_addr;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");
  property p_st_en;
    $rose(s_axi_rvalid) && rd_addr == ADDR_ENABLE_STATUS
      |-> s_axi_rdata[0] == $past(enable_out);
  endproperty
  a_st_en: assert property (p_st_en)
    else $error("status bit differs from enable output");
  property p_st_rsv;
    $rose(s_axi_rvalid) && rd_addr == ADDR_ENABLE_STATUS
      |-> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_st_rsv: assert property (p_st_rsv)
    else $error("status upper bits not zero");
  property p_spk;
    $rose(s_axi_rvalid) && rd_addr == ADDR_SPIKE_LEN
      |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[7:0] != 8'h0;
  endproperty
  a_spk: assert property (p_spk)
    else $error("spike length read out of range");
  property p_oe_en;
    $rose(sda_oe) |-> enable_out;
  endproperty
  a_oe_en: assert property (p_oe_en)
    else $error("acknowledge driven while disabled");
endmodule

bind iess_top iess_sva i_iess_sva (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sda_oe(sda_oe), .enable_out(enable_out)
);
`default_nettype wire

// File: dv/iess_master.sv
// Remote master driving clock and data of the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module iess_master (
  // Lines driven, a one means released
  output logic scl_out,
  output logic sda_out,
  // Resolved data line
  input wire logic sda_line
);
  // Low phase must outlast the slave's reply lag through sync and filter
  localparam int HALF = 500;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic start();
    sda_out = 1'b0;
    #(HALF);
    scl_out = 1'b0;
  endtask

  // Ninth clock reads the answer at the end of its high phase, the
  // latest point, since the slave's reply lags by the filter delay
  task automatic put_byte(input logic [7:0] b, input int gl,
                          output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 2);
      sda_out = (i > 0) ? b[i-1] : 1'b1;
      #(HALF / 2);
      scl_out = 1'b1;
      if (i == 4 && gl > 0) begin
        #(HALF / 2);
        scl_out = 1'b0;
        #(gl);
        scl_out = 1'b1;
      end
      #(HALF);
      ack = !sda_line;
      scl_out = 1'b0;
    end
  endtask

  task automatic stop();
    #(HALF / 2);
    sda_out = 1'b0;
    #(HALF / 2);
    scl_out = 1'b1;
    #(HALF);
    sda_out = 1'b1;
    #(HALF);
  endtask
endmodule
`default_nettype wire

// File: dv/iess_top_tb.sv
// Self-checking bench for the enable-status and spike-filter block
`timescale 1ns/1ns
`default_nettype none
module iess_top_tb
  import iess_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe;
  logic enable_out, irq, m_scl, m_sda, sda_i, ack;
  logic [1:0] bresp, rresp;
  logic [7:0] v, m_spk;
  logic [31:0] seed = 32'h35b72adf;
  int num_errors = 0;
  int checks_done = 0;
  int m_ist, m_msk;
  int msk_t[4] = '{1, 1, 3, 3};
  int clr_t[4] = '{0, 1, 0, 2};

  always #25 aclk = ~aclk;
  assign sda_i = m_sda & (sda_oe ? sda_o : 1'b1);

  iess_top i_iess_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(m_scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .enable_out(enable_out), .irq(irq)
  );
  iess_master i_iess_master (
    .scl_out(m_scl), .sda_out(m_sda), .sda_line(sda_i)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  // Ready is raised late on purpose so the slave must hold its answer
  task automatic acc(input bit wr, input logic [31:0] a, d, e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready)) break;
      n++;
      if (n == 3) bready <= wr;
      if (n == 3) rready <= !wr;
      if (n > 100) begin
        num_errors++;
        report_and_stop();
      end
    end
    bready <= 1'b0;
    rready <= 1'b0;
    chk("resp", {30'h0, er}, {30'h0, wr ? bresp : rresp});
    if (!wr) chk("rdata", e, rdata);
  endtask

  task automatic en_wait();
    for (int n = 0; n < 200 && enable_out !== 1'b0; n++) @(posedge aclk);
    chk("enable_out", 0, enable_out);
  endtask

  task automatic byte_dis(input logic [7:0] b);
    fork
      i_iess_master.put_byte(b, 0, ack);
      begin
        #1600;
        acc(1, ADDR_CONTROL, 0, 0, RESP_OKAY);
      end
    join
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    #500_000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    acc(0, ADDR_ENABLE_STATUS, 0, 0, RESP_OKAY);
    acc(0, ADDR_SPIKE_LEN, 0, 1, RESP_OKAY);
    acc(1, ADDR_ENABLE_STATUS, 32'hffff, 0, RESP_OKAY);
    acc(0, ADDR_ENABLE_STATUS, 0, 0, RESP_OKAY);
    acc(1, 32'h50001500, 1, 0, RESP_SLVERR);
    acc(0, 32'h50001500, 0, 0, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = (i < 3) ? i[7:0] : seed[7:0];
      m_spk = (v < 8'h02) ? 8'h02 : v;
      acc(1, ADDR_SPIKE_LEN, {seed[31:8], v}, 0, RESP_OKAY);
      acc(0, ADDR_SPIKE_LEN, 0, {24'h0, m_spk}, RESP_OKAY);
    end
    acc(1, ADDR_SPIKE_LEN, 3, 0, RESP_OKAY);
    acc(1, ADDR_CONTROL, 1, 0, RESP_OKAY);
    acc(0, ADDR_ENABLE_STATUS, 0, 1, RESP_OKAY);
    acc(1, ADDR_SPIKE_LEN, 9, 0, RESP_OKAY);
    acc(0, ADDR_SPIKE_LEN, 0, 3, RESP_OKAY);
    i_iess_master.start();
    i_iess_master.put_byte({OWN_ADDR_RESET, 1'b0}, 100, ack);
    chk("ack", 1, ack);
    seed = xs(seed);
    i_iess_master.put_byte(seed[7:0], 0, ack);
    chk("ack", 1, ack);
    acc(1, ADDR_CONTROL, 0, 0, RESP_OKAY);
    i_iess_master.stop();
    en_wait();
    acc(0, ADDR_ENABLE_STATUS, 0, 32'h6, RESP_OKAY);
    m_ist = 3;
    for (int i = 0; i < 4; i++) begin
      m_msk = msk_t[i];
      m_ist = m_ist & ~clr_t[i];
      acc(1, ADDR_INT_MASK, m_msk, 0, RESP_OKAY);
      acc(1, ADDR_INT_STATUS, clr_t[i], 0, RESP_OKAY);
      acc(0, ADDR_INT_STATUS, 0, m_ist, RESP_OKAY);
      chk("irq", (m_ist & m_msk) != 0, irq);
    end
    acc(1, ADDR_CONTROL, 1, 0, RESP_OKAY);
    i_iess_master.start();
    byte_dis({OWN_ADDR_RESET, 1'b1});
    chk("ack", 0, ack);
    i_iess_master.stop();
    en_wait();
    acc(0, ADDR_ENABLE_STATUS, 0, 32'h2, RESP_OKAY);
    acc(0, ADDR_ENABLE_STATUS, 0, 32'h2, RESP_OKAY);
    acc(1, ADDR_CONTROL, 1, 0, RESP_OKAY);
    i_iess_master.start();
    i_iess_master.put_byte(8'h24, 0, ack);
    chk("ack", 0, ack);
    seed = xs(seed);
    byte_dis(seed[7:0]);
    i_iess_master.stop();
    en_wait();
    acc(0, ADDR_ENABLE_STATUS, 0, 0, RESP_OKAY);
    report_and_stop();
  end
endmodule
`default_nettype wire
